// ==== pppc_pkg.sv ====
package pppc_pkg;
  // current limit step index, eight ordered steps, 0 is the lowest
  localparam int ILIM_W = 3;
  localparam logic [2:0] ILIM_MIN = 3'h0;
  localparam logic [2:0] ILIM_RESET = 3'h7;
  // profile current bound codes: programmed value or forced 100 mA
  localparam logic PROFILE_PROGRAMMED = 1'b0;
  localparam logic PROFILE_100MA = 1'b1;
  // timing at 40 MHz
  localparam int CLK_MHZ = 40;
  localparam int RETRY_US = 100;
  localparam int RETRY_CYCLES = RETRY_US * CLK_MHZ;
  localparam int RESTORE_US = 100;
  localparam int RESTORE_CYCLES = RESTORE_US * CLK_MHZ;
  localparam int DISCHARGE_US = 200;
  localparam int DISCHARGE_CYCLES = DISCHARGE_US * CLK_MHZ;
  localparam int TIMER_W = 16;
  // rationing action select codes
  localparam logic [1:0] RTN_REPORT = 2'h0;
  localparam logic [1:0] RTN_REPORT_DISC = 2'h1;
  localparam logic [1:0] RTN_DISC_SLEEP = 2'h2;
  localparam logic [1:0] RTN_IGNORE = 2'h3;
  localparam logic [1:0] RTN_RESET = RTN_REPORT_DISC;
  localparam int CHARGE_W = 24;
  localparam logic [23:0] CHARGE_ZERO = 24'h000000;
  // thermal regulation states, one-hot
  typedef enum logic [3:0] {
    TH_NORMAL = 4'b0001,
    TH_OPEN = 4'b0010,
    TH_CHECK = 4'b0100,
    TH_RESTORE = 4'b1000
  } pppc_th_t;
endpackage : pppc_pkg

// ==== pppc_timer_if.sv ====
`timescale 1ns/10ps
// load/expire handshake between the controller and its down-counter
interface pppc_timer_if;
  logic load; // one-cycle pulse starting a count
  logic [15:0] count; // cycles to run
  logic expired; // one-cycle pulse at the end
  logic busy; // level while counting
  modport ctrl (output load, output count, input expired, input busy);
  modport timer (input load, input count, output expired, output busy);
endinterface : pppc_timer_if

// ==== pppc_timer.sv ====
`timescale 1ns/10ps
// reusable down-counter; a new load restarts it
module pppc_timer
(
  input wire logic sys_clk,
  input wire logic resetn,
  pppc_timer_if.timer tif
);
  import pppc_pkg::*;
  logic [TIMER_W-1:0] remain; // cycles left

  // count down, pulse expired on reaching zero
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      remain <= '0;
      tif.expired <= 1'b0;
    end
    else if (tif.load)
    begin
      remain <= tif.count;
      tif.expired <= 1'b0;
    end
    else if (remain != '0)
    begin
      remain <= remain - 1'b1;
      tif.expired <= (remain == 16'h0001);
    end
    else
    begin
      tif.expired <= 1'b0;
    end
  end

  assign tif.busy = (remain != '0);
endmodule : pppc_timer

// ==== pppc_ctrl.sv ====
`timescale 1ns/10ps
// How it works
// R1: above regulation: open, step down, start retry
// R2: retry expiry closes switch, rechecks, repeats
// R3: CC at minimum: force trip, 100 mA, restep
// R4: cool after forced trip: timed restore
// R5: cool without forced change: restore immediately
// R6: trip at minimum and hot: hold closed
// R7: shutdown temperature turns the port switch off
// R8: discharge on enable falling edge
// R9: discharge on removal when detect enabled
// R10: discharge on supply undervoltage switch-off
// R11: discharge on sleep, error recovery, command
// R12: discharge on bypass/port handover when detect enabled
// R13: discharge check fails: error flag, error state
// R14: accumulate only in Active, never on attach
// R15: before threshold, normal operation
// R16: selection change keeps accumulated charge
// R17: after threshold, new selection applies immediately
// R18: select: alert, alert+open, open+sleep, none
// R19: report-disconnect: monitor on, switches held open
// R20: disconnect-sleep: monitors off, enable ignored
// R21: clear control zeroes accumulated charge
// R22: limit is saturating three-bit step index
module pppc_ctrl
#(
  parameter int RETRY_COUNT = pppc_pkg::RETRY_CYCLES,
  parameter int RESTORE_COUNT = pppc_pkg::RESTORE_CYCLES,
  parameter int DISCHARGE_COUNT = pppc_pkg::DISCHARGE_CYCLES,
  parameter int CHARGE_WIDTH = pppc_pkg::CHARGE_W
)
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic OVER_REGULATION,
  input wire logic BELOW_REG_HYSTERESIS,
  input wire logic OVER_SHUTDOWN,
  input wire logic BELOW_SHUTDOWN_HYSTERESIS,
  input wire logic CC_MODE_CFG,
  input wire logic [2:0] PROGRAMMED_LIMIT,
  input wire logic PORT_POWER_ENABLE_CTL,
  input wire logic REMOVAL_EVENT,
  input wire logic ATTACH_DETECT_EN,
  input wire logic SUPPLY_UNDERVOLTAGE,
  input wire logic SLEEP_ENTRY,
  input wire logic ERROR_RECOVERY,
  input wire logic DISCHARGE_CMD,
  input wire logic ACTIVE_STATE,
  input wire logic BYPASS_ON,
  input wire logic VBUS_BELOW_TEST,
  input wire logic CHARGE_TICK,
  input wire logic [pppc_pkg::CHARGE_W-1:0] RATION_THRESHOLD,
  input wire logic [1:0] RATION_ACTION_SEL,
  input wire logic RATION_CLEAR_CTL,
  output logic PORT_SWITCH_CLOSED,
  output logic SHUTDOWN_ACTIVE,
  output logic [2:0] CURRENT_LIMIT_SETTING,
  output logic PROFILE_CURRENT_BOUND,
  output logic TRIP_MODE,
  output logic DISCHARGE_ACTIVE,
  output logic DISCHARGE_ERROR_FLAG,
  output logic ENTER_ERROR,
  output logic [pppc_pkg::CHARGE_W-1:0] ACCUMULATED_CHARGE,
  output logic RATION_REACHED,
  output logic RATION_ALERT,
  output logic RATION_SLEEP,
  output logic MONITOR_ENABLE,
  output logic POWER_ENABLE_FOLLOW
);
  import pppc_pkg::*;

  // saturating one-step decrement of the limit index
  function automatic logic [2:0] step_down(input logic [2:0] idx);
    step_down = (idx == ILIM_MIN) ? ILIM_MIN : idx - 3'h1; // see R22
  endfunction : step_down

  // pin synchronisers: first stage read only by the second
  logic [13:0] sync_a; // first stage
  logic [13:0] sync_b; // second stage
  logic ov_reg, cool_reg, ov_tsd, cool_tsd, port_power_enable_ctl, removal, det_en, uvlo;
  logic bypass, vbus_low, cmd, sleep_in, err_rec, active;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {OVER_REGULATION, BELOW_REG_HYSTERESIS, OVER_SHUTDOWN,
                 BELOW_SHUTDOWN_HYSTERESIS, PORT_POWER_ENABLE_CTL, REMOVAL_EVENT,
                 ATTACH_DETECT_EN, SUPPLY_UNDERVOLTAGE, BYPASS_ON, VBUS_BELOW_TEST,
                 DISCHARGE_CMD, SLEEP_ENTRY, ERROR_RECOVERY, ACTIVE_STATE};
      sync_b <= sync_a;
    end
  end

  assign {ov_reg, cool_reg, ov_tsd, cool_tsd, port_power_enable_ctl, removal, det_en, uvlo,
          bypass, vbus_low, cmd, sleep_in, err_rec, active} = sync_b;

  // delayed copies for edge detection
  logic port_power_enable_ctl_d, removal_d, uvlo_d, bypass_d, sleep_d, err_d, cmd_d;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      port_power_enable_ctl_d <= 1'b0;
      removal_d <= 1'b0;
      uvlo_d <= 1'b0;
      bypass_d <= 1'b0;
      sleep_d <= 1'b0;
      err_d <= 1'b0;
      cmd_d <= 1'b0;
    end
    else
    begin
      port_power_enable_ctl_d <= port_power_enable_ctl;
      removal_d <= removal;
      uvlo_d <= uvlo;
      bypass_d <= bypass;
      sleep_d <= sleep_in;
      err_d <= err_rec;
      cmd_d <= cmd;
    end
  end

  // one timer for thermal retry/restore, one for discharge
  pppc_timer_if th_tif();
  pppc_timer_if dc_tif();

  pppc_timer u_th_timer
  (
    .sys_clk(SYS_CLK),
    .resetn(RESETN),
    .tif(th_tif)
  );

  pppc_timer u_dc_timer
  (
    .sys_clk(SYS_CLK),
    .resetn(RESETN),
    .tif(dc_tif)
  );

  // thermal regulation state machine
  pppc_th_t th_state;
  logic forced_trip; // mode was forced from cc to trip
  logic th_open; // regulation holds the switch open
  logic th_load; // start thermal timer
  logic [15:0] th_count;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      th_state <= TH_NORMAL;
      CURRENT_LIMIT_SETTING <= ILIM_RESET;
      PROFILE_CURRENT_BOUND <= PROFILE_PROGRAMMED;
      forced_trip <= 1'b0;
      th_open <= 1'b0;
      th_load <= 1'b0;
      th_count <= '0;
    end
    else
    begin
      th_load <= 1'b0;
      case (th_state)
        TH_NORMAL:
        begin
          // track the programmed limit while idle
          CURRENT_LIMIT_SETTING <= PROGRAMMED_LIMIT;
          PROFILE_CURRENT_BOUND <= PROFILE_PROGRAMMED;
          forced_trip <= 1'b0;
          if (ov_reg)
          begin
            th_open <= 1'b1; // see R1
            CURRENT_LIMIT_SETTING <= step_down(PROGRAMMED_LIMIT); // see R1
            th_count <= 16'(RETRY_COUNT);
            th_load <= 1'b1;
            th_state <= TH_OPEN;
          end
        end
        TH_OPEN:
        begin
          // wait out the retry interval, then close and recheck
          if (th_tif.expired)
          begin
            th_open <= 1'b0; // see R2
            th_state <= TH_CHECK;
          end
        end
        TH_CHECK:
        begin
          if (cool_reg)
          begin
            if (forced_trip)
            begin
              th_count <= 16'(RESTORE_COUNT); // see R4
              th_load <= 1'b1;
              th_state <= TH_RESTORE;
            end
            else
              th_state <= TH_NORMAL; // see R5
          end
          else if (ov_reg)
          begin
            if (CURRENT_LIMIT_SETTING != ILIM_MIN)
            begin
              th_open <= 1'b1; // see R2
              CURRENT_LIMIT_SETTING <= step_down(CURRENT_LIMIT_SETTING);
              th_count <= 16'(RETRY_COUNT);
              th_load <= 1'b1;
              th_state <= TH_OPEN;
            end
            else if (CC_MODE_CFG && !forced_trip)
            begin
              forced_trip <= 1'b1; // see R3
              PROFILE_CURRENT_BOUND <= PROFILE_100MA; // see R3
              CURRENT_LIMIT_SETTING <= step_down(PROGRAMMED_LIMIT); // see R3
              th_open <= 1'b1;
              th_count <= 16'(RETRY_COUNT);
              th_load <= 1'b1;
              th_state <= TH_OPEN;
            end
            // trip at minimum: stay closed at lowest limit, see R6
          end
        end
        TH_RESTORE:
        begin
          // reheating cancels the restore and resumes stepping
          if (ov_reg)
            th_state <= TH_CHECK;
          else if (th_tif.expired)
            th_state <= TH_NORMAL; // see R4
        end
        default:
          th_state <= TH_NORMAL;
      endcase
    end
  end

  assign th_tif.load = th_load;
  assign th_tif.count = th_count;
  assign TRIP_MODE = forced_trip | !CC_MODE_CFG;

  // hard shutdown, held until below the lower threshold
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    // the hot test comes first so a hot reading beats the release
    if (!RESETN)
      SHUTDOWN_ACTIVE <= 1'b0;
    else if (ov_tsd)
      SHUTDOWN_ACTIVE <= 1'b1; // see R7
    else if (cool_tsd)
      SHUTDOWN_ACTIVE <= 1'b0; // see R7
  end

  // rationing: accumulate, threshold, action selection
  logic sleep_latched; // disconnect-and-sleep engaged

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ACCUMULATED_CHARGE <= CHARGE_ZERO;
    end
    else if (RATION_CLEAR_CTL)
    begin
      ACCUMULATED_CHARGE <= CHARGE_ZERO; // see R21
    end
    else if (active && CHARGE_TICK && !RATION_REACHED
             && ACCUMULATED_CHARGE != '1)
    begin
      // attach/removal never touch the total; selection neither, see R16
      ACCUMULATED_CHARGE <= ACCUMULATED_CHARGE + 1'b1; // see R14
    end
  end

  // threshold flag; comparison is live so a selection change acts at once
  assign RATION_REACHED = (RATION_THRESHOLD != CHARGE_ZERO)
                          && (ACCUMULATED_CHARGE >= RATION_THRESHOLD); // see R15

  always_comb
  begin
    RATION_ALERT = 1'b0;
    if (RATION_REACHED)
    begin
      // action follows the selection live, see R17
      RATION_ALERT = (RATION_ACTION_SEL == RTN_REPORT)
                     || (RATION_ACTION_SEL == RTN_REPORT_DISC); // see R18
    end
  end

  assign sleep_latched = RATION_REACHED && (RATION_ACTION_SEL == RTN_DISC_SLEEP);
  assign RATION_SLEEP = sleep_latched; // see R18
  assign MONITOR_ENABLE = !sleep_latched; // see R20
  assign POWER_ENABLE_FOLLOW = !sleep_latched; // see R20

  // ration forces the switch open in both disconnect modes
  logic ration_open;
  assign ration_open = RATION_REACHED && ((RATION_ACTION_SEL == RTN_REPORT_DISC)
                       || (RATION_ACTION_SEL == RTN_DISC_SLEEP)); // see R19

  // port switch drive
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PORT_SWITCH_CLOSED <= 1'b0;
    end
    else
    begin
      PORT_SWITCH_CLOSED <= port_power_enable_ctl && !uvlo && !SHUTDOWN_ACTIVE && !ov_tsd
                            && !th_open && !ration_open && !DISCHARGE_ACTIVE
                            && !ENTER_ERROR; // see R7
    end
  end

  // discharge triggers are edges of the synchronised controls
  logic dc_start;
  logic en_fall, rem_rise, uv_rise, handover;
  assign en_fall = port_power_enable_ctl_d && !port_power_enable_ctl && POWER_ENABLE_FOLLOW; // see R8
  assign rem_rise = det_en && removal && !removal_d; // see R9
  assign uv_rise = uvlo && !uvlo_d; // see R10
  assign handover = det_en && (bypass != bypass_d); // see R12
  assign dc_start = en_fall || rem_rise || uv_rise || handover
                    || (sleep_in && !sleep_d) || (err_rec && !err_d)
                    || (cmd && !cmd_d && active); // see R11

  assign dc_tif.load = dc_start && !DISCHARGE_ACTIVE;
  assign dc_tif.count = 16'(DISCHARGE_COUNT);

  // discharge interval, then verify the bus level
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      DISCHARGE_ACTIVE <= 1'b0;
      DISCHARGE_ERROR_FLAG <= 1'b0;
      ENTER_ERROR <= 1'b0;
    end
    else
    begin
      ENTER_ERROR <= 1'b0;
      if (dc_tif.load)
      begin
        DISCHARGE_ACTIVE <= 1'b1;
      end
      else if (dc_tif.expired)
      begin
        DISCHARGE_ACTIVE <= 1'b0;
        if (!vbus_low)
        begin
          DISCHARGE_ERROR_FLAG <= 1'b1; // see R13
          ENTER_ERROR <= 1'b1; // see R13
        end
      end
      // recovery clears the sticky flag unless a failure lands now
      if (err_rec && !err_d && !(dc_tif.expired && !vbus_low))
      begin
        DISCHARGE_ERROR_FLAG <= 1'b0;
      end
    end
  end
endmodule : pppc_ctrl

// ==== pppc_ctrl_assertions.sv ====
`timescale 1ns/10ps
// port-side checks of the protection controller
module pppc_ctrl_assertions
#(
  parameter int DISCHARGE_COUNT = 8
)
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic OVER_SHUTDOWN,
  input wire logic CC_MODE_CFG,
  input wire logic [2:0] PROGRAMMED_LIMIT,
  input wire logic [1:0] RATION_ACTION_SEL,
  input wire logic RATION_CLEAR_CTL,
  input wire logic PORT_SWITCH_CLOSED,
  input wire logic SHUTDOWN_ACTIVE,
  input wire logic [2:0] CURRENT_LIMIT_SETTING,
  input wire logic PROFILE_CURRENT_BOUND,
  input wire logic TRIP_MODE,
  input wire logic DISCHARGE_ACTIVE,
  input wire logic DISCHARGE_ERROR_FLAG,
  input wire logic ENTER_ERROR,
  input wire logic [pppc_pkg::CHARGE_W-1:0] ACCUMULATED_CHARGE,
  input wire logic RATION_REACHED,
  input wire logic RATION_ALERT,
  input wire logic RATION_SLEEP,
  input wire logic MONITOR_ENABLE
);
  import pppc_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  logic [15:0] dis_len; // cycles spent in the current discharge
  // count discharge length; the end is one cycle after the timer runs out
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      dis_len <= 16'h0;
    end
    else
    begin
      dis_len <= DISCHARGE_ACTIVE ? dis_len + 16'h1 : 16'h0;
    end
  end
  shutdown_off_a: assert property ($rose(OVER_SHUTDOWN) |-> ##[2:4] SHUTDOWN_ACTIVE)
    else $error("shutdown not raised");
  shutdown_hold_a: assert property (SHUTDOWN_ACTIVE |-> !PORT_SWITCH_CLOSED)
    else $error("switch closed in shutdown");
  limit_step_a: assert property ((CURRENT_LIMIT_SETTING < $past(CURRENT_LIMIT_SETTING))
    && PROGRAMMED_LIMIT == $past(PROGRAMMED_LIMIT, 2)
    |-> CURRENT_LIMIT_SETTING == $past(CURRENT_LIMIT_SETTING) - 3'h1)
    else $error("limit skipped a step");
  step_open_a: assert property ((CURRENT_LIMIT_SETTING < $past(CURRENT_LIMIT_SETTING))
    && PROGRAMMED_LIMIT == $past(PROGRAMMED_LIMIT, 2)
    |=> !PORT_SWITCH_CLOSED)
    else $error("step down with switch closed");
  trip_bound_a: assert property ($rose(TRIP_MODE) && CC_MODE_CFG |-> PROFILE_CURRENT_BOUND)
    else $error("forced trip without 100 mA bound");
  dis_end_a: assert property ($fell(DISCHARGE_ACTIVE)
    |-> $past(dis_len) == DISCHARGE_COUNT)
    else $error("discharge length wrong");
  err_pulse_a: assert property ($rose(DISCHARGE_ERROR_FLAG)
    |-> ENTER_ERROR && !DISCHARGE_ACTIVE ##1 !ENTER_ERROR)
    else $error("error entry not a single pulse");
  alert_sel_a: assert property (RATION_ALERT == (RATION_REACHED && !RATION_ACTION_SEL[1]))
    else $error("alert does not follow selection");
  sleep_sel_a: assert property (RATION_SLEEP
    == (RATION_REACHED && RATION_ACTION_SEL == RTN_DISC_SLEEP))
    else $error("sleep does not follow selection");
  monitor_a: assert property (MONITOR_ENABLE
    == !(RATION_REACHED && RATION_ACTION_SEL == RTN_DISC_SLEEP))
    else $error("monitor enable wrong");
  ration_open_a: assert property (RATION_REACHED && (RATION_ACTION_SEL == RTN_REPORT_DISC
    || RATION_ACTION_SEL == RTN_DISC_SLEEP) |=> !PORT_SWITCH_CLOSED)
    else $error("switch closed after ration");
  charge_step_a: assert property (ACCUMULATED_CHARGE != $past(ACCUMULATED_CHARGE)
    |-> ACCUMULATED_CHARGE == $past(ACCUMULATED_CHARGE) + 24'h1
    || ACCUMULATED_CHARGE == CHARGE_ZERO)
    else $error("charge jumped");
  clear_a: assert property (RATION_CLEAR_CTL |-> ##[1:3] ACCUMULATED_CHARGE == CHARGE_ZERO)
    else $error("clear did not zero charge");
  cover property ($fell(DISCHARGE_ACTIVE));
  cover property ($rose(RATION_REACHED));
  cover property ($rose(ENTER_ERROR));
endmodule : pppc_ctrl_assertions

// ==== pppc_vbus_model.sv ====
`timescale 1ns/10ps
// bus line as seen by the test comparator; stuck models a load holding it up
module pppc_vbus_model
(
  input wire logic sys_clk,
  input wire logic discharging,
  input wire logic switch_closed,
  input wire logic stuck,
  output logic below_test
);
  logic level_low = 1'b0; // bus starts charged
  // a discharge pulls the bus low unless the load fights it
  always @(posedge sys_clk)
  begin
    if (discharging && !stuck)
    begin
      level_low <= 1'b1;
    end
    else if (switch_closed || stuck)
    begin
      level_low <= 1'b0;
    end
  end
  assign below_test = level_low;
endmodule : pppc_vbus_model

// ==== port_power_protection_ctrl_tb_top.sv ====
`timescale 1ns/10ps
module port_power_protection_ctrl_tb_top;
  import pppc_pkg::*;
  typedef struct {logic [1:0] sel; logic alert; logic sleep; logic mon;
    logic closed;} pppc_row_t;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic OVER_REGULATION, BELOW_REG_HYSTERESIS, OVER_SHUTDOWN, BELOW_SHUTDOWN_HYSTERESIS;
  logic CC_MODE_CFG, PORT_POWER_ENABLE_CTL, REMOVAL_EVENT, ATTACH_DETECT_EN;
  logic SUPPLY_UNDERVOLTAGE, SLEEP_ENTRY, ERROR_RECOVERY, DISCHARGE_CMD, ACTIVE_STATE;
  logic BYPASS_ON, VBUS_BELOW_TEST, CHARGE_TICK, RATION_CLEAR_CTL, vbus_stuck;
  logic [2:0] PROGRAMMED_LIMIT, CURRENT_LIMIT_SETTING;
  logic [1:0] RATION_ACTION_SEL;
  logic [23:0] RATION_THRESHOLD, ACCUMULATED_CHARGE;
  logic PORT_SWITCH_CLOSED, SHUTDOWN_ACTIVE, PROFILE_CURRENT_BOUND, TRIP_MODE;
  logic DISCHARGE_ACTIVE, DISCHARGE_ERROR_FLAG, ENTER_ERROR, RATION_REACHED;
  logic RATION_ALERT, RATION_SLEEP, MONITOR_ENABLE, POWER_ENABLE_FOLLOW;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // every selection after the threshold: alert, sleep, monitor, switch closed
  pppc_row_t rows [4] = '{'{RTN_REPORT, 1'b1, 1'b0, 1'b1, 1'b1},
    '{RTN_REPORT_DISC, 1'b1, 1'b0, 1'b1, 1'b0}, '{RTN_DISC_SLEEP, 1'b0, 1'b1, 1'b0, 1'b0},
    '{RTN_IGNORE, 1'b0, 1'b0, 1'b1, 1'b1}};
  // short counts keep the run brief
  pppc_ctrl #(.RETRY_COUNT(8), .RESTORE_COUNT(8), .DISCHARGE_COUNT(8)) dut (.*);
  pppc_vbus_model vbus (.sys_clk(SYS_CLK), .discharging(DISCHARGE_ACTIVE),
    .switch_closed(PORT_SWITCH_CLOSED), .stuck(vbus_stuck), .below_test(VBUS_BELOW_TEST));
  always #12.5 SYS_CLK = ~SYS_CLK;
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // inputs always move 2 ns after the edge
  task step(input int n);
    repeat (n) @(posedge SYS_CLK);
    #2;
  endtask : step
  task tick;
    CHARGE_TICK = 1'b1;
    step(1);
    CHARGE_TICK = 1'b0;
    step(1);
  endtask : tick
  // a trigger shows as an active discharge, which must then end
  task dis_chk(input logic e);
    step(6);
    chk(DISCHARGE_ACTIVE, e);
    step(12);
    chk(DISCHARGE_ACTIVE, 1'b0);
  endtask : dis_chk
  // hang guard, run needs well under a thousand cycles
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      end_of_test();
    end
  end
  initial
  begin
    {OVER_REGULATION, BELOW_REG_HYSTERESIS, OVER_SHUTDOWN, BELOW_SHUTDOWN_HYSTERESIS} = '0;
    {CC_MODE_CFG, REMOVAL_EVENT, ATTACH_DETECT_EN, SUPPLY_UNDERVOLTAGE, SLEEP_ENTRY} = '0;
    {ERROR_RECOVERY, DISCHARGE_CMD, BYPASS_ON, CHARGE_TICK, RATION_CLEAR_CTL} = '0;
    {vbus_stuck, ACTIVE_STATE, PORT_POWER_ENABLE_CTL} = 3'h3;
    PROGRAMMED_LIMIT = 3'h7;
    RATION_ACTION_SEL = RTN_REPORT;
    RATION_THRESHOLD = 24'h3;
    step(20);
    RESETN = 1'b1;
    chk(CURRENT_LIMIT_SETTING, ILIM_RESET);
    chk(ACCUMULATED_CHARGE, CHARGE_ZERO);
    step(3);
    tick();
    tick();
    chk(RATION_ALERT, 1'b0);
    tick();
    chk(RATION_REACHED, 1'b1);
    foreach (rows[i])
    begin
      RATION_ACTION_SEL = rows[i].sel;
      step(1);
      chk(RATION_ALERT, rows[i].alert);
      chk(RATION_SLEEP, rows[i].sleep);
      chk(MONITOR_ENABLE, rows[i].mon);
      chk(POWER_ENABLE_FOLLOW, rows[i].mon);
      chk(PORT_SWITCH_CLOSED, rows[i].closed);
      chk(ACCUMULATED_CHARGE, 24'h3);
    end
    RATION_CLEAR_CTL = 1'b1;
    step(1);
    RATION_CLEAR_CTL = 1'b0;
    step(2);
    chk(RATION_REACHED, 1'b0);
    ACTIVE_STATE = 1'b0;
    step(3);
    tick();
    chk(ACCUMULATED_CHARGE, CHARGE_ZERO);
    ACTIVE_STATE = 1'b1;
    // hot in trip mode: step down, then hold closed at the floor
    OVER_REGULATION = 1'b1;
    step(4);
    chk(CURRENT_LIMIT_SETTING, 3'h6);
    chk(PORT_SWITCH_CLOSED, 1'b0);
    step(100);
    chk(CURRENT_LIMIT_SETTING, ILIM_MIN);
    chk(PORT_SWITCH_CLOSED, 1'b1);
    {OVER_REGULATION, BELOW_REG_HYSTERESIS} = 2'h1;
    step(6);
    chk(CURRENT_LIMIT_SETTING, 3'h7);
    // constant current at the floor is forced to trip, then timed back
    {OVER_REGULATION, BELOW_REG_HYSTERESIS, CC_MODE_CFG} = 3'h5;
    PROGRAMMED_LIMIT = 3'h4;
    step(150);
    chk({TRIP_MODE, PROFILE_CURRENT_BOUND}, 2'h3);
    {OVER_REGULATION, BELOW_REG_HYSTERESIS} = 2'h1;
    step(4);
    chk(TRIP_MODE, 1'b1);
    step(16);
    chk({TRIP_MODE, PROFILE_CURRENT_BOUND, CURRENT_LIMIT_SETTING}, 5'h4);
    OVER_SHUTDOWN = 1'b1;
    step(4);
    chk({SHUTDOWN_ACTIVE, PORT_SWITCH_CLOSED}, 2'h2);
    OVER_SHUTDOWN = 1'b0;
    step(4);
    chk(SHUTDOWN_ACTIVE, 1'b1);
    BELOW_SHUTDOWN_HYSTERESIS = 1'b1;
    step(4);
    chk(SHUTDOWN_ACTIVE, 1'b0);
    DISCHARGE_CMD = 1'b1;
    dis_chk(1'b1);
    chk(DISCHARGE_ERROR_FLAG, 1'b0);
    DISCHARGE_CMD = 1'b0;
    SLEEP_ENTRY = 1'b1;
    dis_chk(1'b1);
    PORT_POWER_ENABLE_CTL = 1'b0;
    dis_chk(1'b1);
    dis_chk(1'b0);
    {PORT_POWER_ENABLE_CTL, SUPPLY_UNDERVOLTAGE} = 2'h3;
    dis_chk(1'b1);
    REMOVAL_EVENT = 1'b1;
    dis_chk(1'b0);
    {REMOVAL_EVENT, ATTACH_DETECT_EN} = 2'h1;
    step(3);
    REMOVAL_EVENT = 1'b1;
    dis_chk(1'b1);
    BYPASS_ON = 1'b1;
    dis_chk(1'b1);
    BYPASS_ON = 1'b0;
    dis_chk(1'b1);
    vbus_stuck = 1'b1;
    DISCHARGE_CMD = 1'b1;
    step(6);
    for (int k = 0; k < 30 && ENTER_ERROR !== 1'b1; k++)
      step(1);
    chk({ENTER_ERROR, DISCHARGE_ERROR_FLAG}, 2'h3);
    {vbus_stuck, ERROR_RECOVERY} = 2'h1;
    dis_chk(1'b1);
    chk(DISCHARGE_ERROR_FLAG, 1'b0);
    end_of_test();
  end
endmodule : port_power_protection_ctrl_tb_top
bind pppc_ctrl pppc_ctrl_assertions #(.DISCHARGE_COUNT(8)) chk_i (.*);
